// file: logic/ispi_defines.vh
/*
  Constants for the instrument serial slave port: frame lengths, command
  codes, configuration sequencing counts and FIFO shape.
  Assumes a 100 MHz system clock.
*/
`ifndef ISPI_DEFINES_VH
`define ISPI_DEFINES_VH

// =============================================================
// Frame layout
`define ISPI_CMD_BITS        16
`define ISPI_LEN8            2'd0
`define ISPI_LEN16           2'd1
`define ISPI_LEN32           2'd2
`define ISPI_LEN_HI          15
`define ISPI_LEN_LO          14
`define ISPI_FRAME_W         48

// =============================================================
// FIFO shape
`define ISPI_FIFO_W          50
`define ISPI_FIFO_DEPTH      8
`define ISPI_FIFO_AW         3

// =============================================================
// Configuration timing
`define ISPI_CLEAR_NS        1000
`define ISPI_CLK_NS          10
`define ISPI_CLEAR_CYC       ((`ISPI_CLEAR_NS + `ISPI_CLK_NS - 1) / `ISPI_CLK_NS)
`define ISPI_CNT_W           8

`endif

// file: logic/ispi_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides, flip-flop storage.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module ispi_fifo #(
  parameter WIDTH = 50,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             srst_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wptr_r;
  reg [AW-1:0]    rptr_r;
  reg [AW:0]      cnt_r;
  wire            wr;
  wire            rd;

  // =============================================================
  // Flags
  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rptr_r];
  assign wr          = in_valid_i & in_ready_o;
  assign rd          = out_valid_o & out_ready_i;

  // =============================================================
  // Storage and pointers
  always @(posedge clk_i) begin
    if (srst_i) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      cnt_r  <= {(AW+1){1'b0}};
    end else begin
      if (wr) begin
        mem_r[wptr_r] <= in_data_i;
        wptr_r        <= wptr_r + 1'b1;
      end
      if (rd)
        rptr_r <= rptr_r + 1'b1;
      if (wr && !rd)
        cnt_r <= cnt_r + 1'b1;
      else if (rd && !wr)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// file: logic/ispi_cfg.v
/*
  Configuration sequencer of the programmable logic device: housecleaning,
  load with integrity check, completion, post-load error reporting.
  Assumes program request and load status are synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "ispi_defines.vh"
module ispi_cfg (
  // Clock and reset
  input  wire clk_i,
  input  wire srst_i,
  // Control
  input  wire prog_req_i,
  input  wire load_done_i,
  input  wire load_crc_err_i,
  input  wire post_crc_en_i,
  input  wire post_crc_err_i,
  // Status
  output reg  init_low_o,
  output reg  done_o,
  output reg  master_reset_o
);
  localparam ST_CLEAR = 4'b0001;
  localparam ST_LOAD  = 4'b0010;
  localparam ST_ERR   = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  reg [3:0]              state_r;
  reg [`ISPI_CNT_W-1:0]  cnt_r;

  // =============================================================
  // Sequencer
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_r        <= ST_CLEAR;
      cnt_r          <= {`ISPI_CNT_W{1'b0}};
      init_low_o     <= 1'b1;
      done_o         <= 1'b0;
      master_reset_o <= 1'b1;
    end else if (prog_req_i) begin
      state_r        <= ST_CLEAR;
      cnt_r          <= {`ISPI_CNT_W{1'b0}};
      init_low_o     <= 1'b1;
      done_o         <= 1'b0;
      master_reset_o <= 1'b1;
    end else begin
      case (state_r)
        ST_CLEAR: begin
          init_low_o <= 1'b1;
          if (cnt_r == `ISPI_CLEAR_CYC - 1) begin
            state_r        <= ST_LOAD;
            init_low_o     <= 1'b0;
            master_reset_o <= 1'b0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_LOAD: begin
          if (load_crc_err_i) begin
            state_r    <= ST_ERR;
            init_low_o <= 1'b1;
          end else if (load_done_i) begin
            state_r <= ST_DONE;
            done_o  <= 1'b1;
          end
        end
        ST_ERR: begin
          init_low_o <= 1'b1;
        end
        ST_DONE: begin
          if (post_crc_en_i && post_crc_err_i)
            init_low_o <= 1'b1;
        end
        default: begin
          state_r <= ST_CLEAR;
        end
      endcase
    end
  end
endmodule

// file: logic/ispi_port.v
/*
  Instrument serial slave port: mode-0 serial receiver for command plus
  payload frames, byte-ready hold-off, interrupt line, reset input and
  configuration lines of the programmable device.
  Assumes all link pins are asynchronous to clk_i; serial clock well
  below clk_i/4.

  // Function
  // - The first sixteen bits after select falls are the command word.
  // - The command is followed by 8, 16 or 32 payload bits in the same select.
  // - The byte-ready flag high lets the host proceed, low holds it off.
  // - The byte-ready output is high coming out of reset.
  // - The interrupt line is active low and high after reset.
  // - A low system reset input resets the logic and is input only.
  // - Asserting the program line starts configuration.
  // - Asserting the program line also forces a master reset.
  // - Configuration starts by itself at power-up.
  // - The init line is low while configuration memory is cleared.
  // - The init line goes low when the bitstream fails its check.
  // - The init line may report a post-configuration integrity error when enabled.
  // - The completion line goes high only after a successful load.
  // - One host per port and the four wires stay a plain serial port.
*/
`timescale 1ns/1ps
`include "ispi_defines.vh"
module ispi_port (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     srst_i,
  // Serial link
  input  wire                     sck_i,
  input  wire                     mosi_i,
  input  wire                     select_n_i,
  output reg                      miso_o,
  output wire                     miso_oe_o,
  // Sideband
  output reg                      instrument_irq_n_o,
  output wire                     instrument_irq_n_oe_o,
  output reg                      host_go_out_o,
  output wire                     host_go_out_oe_o,
  input  wire                     system_reset_n_i,
  // Configuration lines
  input  wire                     cfg_line_0_i,
  output wire                     cfg_line_1_o,
  output wire                     cfg_line_1_oe_o,
  output wire                     cfg_line_2_o,
  output wire                     cfg_line_2_oe_o,
  output wire                     cfg_master_reset_o,
  // Configuration status from the loader
  input  wire                     load_done_i,
  input  wire                     load_crc_err_i,
  input  wire                     post_crc_en_i,
  input  wire                     post_crc_err_i,
  // Frame stream out
  output wire                     frame_valid_o,
  input  wire                     frame_ready_i,
  output wire [`ISPI_CMD_BITS-1:0] frame_cmd_o,
  output wire [31:0]              frame_data_o,
  output wire [1:0]               frame_len_o,
  // Reply and events
  input  wire [7:0]               reply_byte_i,
  input  wire                     irq_req_i
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_PUSH = 3'b100;

  // =============================================================
  // Synchronisers
  reg [1:0] sck_s_r;
  reg [1:0] mosi_s_r;
  reg [1:0] sel_s_r;
  reg [1:0] rst_s_r;
  reg [1:0] prog_s_r;
  reg       sck_d_r;
  reg       sel_d_r;
  reg       prog_d_r;

  always @(posedge clk_i) begin
    sck_s_r  <= {sck_s_r[0], sck_i};
    mosi_s_r <= {mosi_s_r[0], mosi_i};
    sel_s_r  <= {sel_s_r[0], select_n_i};
    rst_s_r  <= {rst_s_r[0], system_reset_n_i};
    prog_s_r <= {prog_s_r[0], cfg_line_0_i};
  end

  wire rst = srst_i | ~rst_s_r[1];
  wire sel = ~sel_s_r[1];

  always @(posedge clk_i) begin
    if (rst) begin
      sck_d_r  <= 1'b0;
      sel_d_r  <= 1'b0;
      prog_d_r <= 1'b1;
    end else begin
      sck_d_r  <= sck_s_r[1];
      sel_d_r  <= sel;
      prog_d_r <= prog_s_r[1];
    end
  end

  wire sck_rise = sck_s_r[1] & ~sck_d_r;
  wire sck_fall = ~sck_s_r[1] & sck_d_r;
  wire prog_req = ~prog_s_r[1] & prog_d_r;

  // =============================================================
  // Length from command bits
  function [5:0] ispi_total;
    input [1:0] len;
    begin
      case (len)
        `ISPI_LEN8:  ispi_total = 6'd24;
        `ISPI_LEN16: ispi_total = 6'd32;
        default:     ispi_total = 6'd48;
      endcase
    end
  endfunction

  // =============================================================
  // Receiver
  reg [2:0]                 state_r;
  reg [2:0]                 state_nxt;
  reg [`ISPI_FRAME_W-1:0]   shreg_r;
  reg [5:0]                 bitcnt_r;
  reg [1:0]                 len_r;
  reg [2:0]                 tx_bit_r;
  reg                       start_pend_r;
  wire                      fifo_in_ready;
  wire [`ISPI_FIFO_W-1:0]   fifo_out;
  wire [5:0]                next_cnt = bitcnt_r + 6'd1;
  wire [1:0]                cmd_len = shreg_r[`ISPI_LEN_HI-1:`ISPI_LEN_LO-1];
  wire                      sel_fall = sel & ~sel_d_r;
  wire                      start_evt = sel & (sel_fall | start_pend_r);
  wire                      last_bit = (next_cnt > `ISPI_CMD_BITS) && (next_cnt == ispi_total(len_r));

  // =============================================================
  // Frame start held while a hand-over is pending
  always @(posedge clk_i) begin
    if (rst) begin
      start_pend_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      start_pend_r <= 1'b0;
    end else if (sel_fall) begin
      start_pend_r <= 1'b1;
    end
  end

  // =============================================================
  // Receiver next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_evt)
          state_nxt = ST_SHIFT;
      end
      ST_SHIFT: begin
        if (!sel)
          state_nxt = ST_IDLE;
        else if (sck_rise && last_bit)
          state_nxt = ST_PUSH;
      end
      ST_PUSH: begin
        if (fifo_in_ready)
          state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // =============================================================
  // Receiver datapath
  always @(posedge clk_i) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      shreg_r  <= {`ISPI_FRAME_W{1'b0}};
      bitcnt_r <= 6'd0;
      len_r    <= `ISPI_LEN8;
      tx_bit_r <= 3'd7;
      miso_o   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_IDLE: begin
          bitcnt_r <= 6'd0;
          tx_bit_r <= 3'd7;
          if (start_evt) begin
            miso_o   <= reply_byte_i[7];
            tx_bit_r <= 3'd6;
          end
        end
        ST_SHIFT: begin
          if (sel && sck_rise) begin
            shreg_r  <= {shreg_r[`ISPI_FRAME_W-2:0], mosi_s_r[1]};
            bitcnt_r <= next_cnt;
            if (next_cnt == `ISPI_CMD_BITS)
              len_r <= cmd_len;
          end else if (sel && sck_fall) begin
            miso_o   <= reply_byte_i[tx_bit_r];
            tx_bit_r <= tx_bit_r - 3'd1;
          end
        end
        default: begin
          tx_bit_r <= 3'd7;
        end
      endcase
    end
  end

  // =============================================================
  // Frame alignment, command on top and payload right aligned
  function [`ISPI_FRAME_W-1:0] ispi_align;
    input [1:0]               len;
    input [`ISPI_FRAME_W-1:0] sr;
    begin
      case (len)
        `ISPI_LEN8:  ispi_align = {sr[23:0], 24'h000000};
        `ISPI_LEN16: ispi_align = {sr[31:0], 16'h0000};
        default:     ispi_align = sr;
      endcase
    end
  endfunction

  function [31:0] ispi_payload;
    input [1:0]               len;
    input [`ISPI_FRAME_W-1:0] al;
    begin
      case (len)
        `ISPI_LEN8:  ispi_payload = {24'h000000, al[31:24]};
        `ISPI_LEN16: ispi_payload = {16'h0000, al[31:16]};
        default:     ispi_payload = al[31:0];
      endcase
    end
  endfunction

  wire [`ISPI_FRAME_W-1:0] frame_al = ispi_align(len_r, shreg_r);
  wire [31:0]              pay      = ispi_payload(len_r, frame_al);
  wire [`ISPI_FIFO_W-1:0]  fifo_in  = {len_r, frame_al[47:32], pay};

  // =============================================================
  // Master-in enable
  assign miso_oe_o = (state_r != ST_IDLE) & sel;

  // =============================================================
  // Frame FIFO
  ispi_fifo #(
    .WIDTH (`ISPI_FIFO_W),
    .DEPTH (`ISPI_FIFO_DEPTH),
    .AW    (`ISPI_FIFO_AW)
  ) i_ispi_fifo (
    .clk_i       (clk_i),
    .srst_i      (rst),
    .in_valid_i  (state_r == ST_PUSH),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in),
    .out_valid_o (frame_valid_o),
    .out_ready_i (frame_ready_i),
    .out_data_o  (fifo_out)
  );

  assign frame_len_o  = fifo_out[49:48];
  assign frame_cmd_o  = fifo_out[47:32];
  assign frame_data_o = fifo_out[31:0];

  // =============================================================
  // Sideband outputs
  always @(posedge clk_i) begin
    if (rst) begin
      host_go_out_o      <= 1'b1;
      instrument_irq_n_o <= 1'b1;
    end else begin
      host_go_out_o      <= fifo_in_ready && (state_r != ST_PUSH);
      instrument_irq_n_o <= ~irq_req_i;
    end
  end

  assign host_go_out_oe_o      = 1'b1;
  assign instrument_irq_n_oe_o = 1'b1;

  // =============================================================
  // Configuration sequencer
  wire init_low;
  wire cfg_done;

  ispi_cfg i_ispi_cfg (
    .clk_i          (clk_i),
    .srst_i         (rst),
    .prog_req_i     (prog_req),
    .load_done_i    (load_done_i),
    .load_crc_err_i (load_crc_err_i),
    .post_crc_en_i  (post_crc_en_i),
    .post_crc_err_i (post_crc_err_i),
    .init_low_o     (init_low),
    .done_o         (cfg_done),
    .master_reset_o (cfg_master_reset_o)
  );

  // Open-drain init: drive low only
  assign cfg_line_1_o    = 1'b0;
  assign cfg_line_1_oe_o = init_low;
  assign cfg_line_2_o    = cfg_done;
  assign cfg_line_2_oe_o = 1'b1;
endmodule

// file: bench/ispi_port_properties.sv
/*
  Checker of the serial slave port top: reset levels, interrupt,
  master-in release, configuration lines and frame hand-over.
  Assumes it is bound onto ispi_port and sees only its ports.
*/
`timescale 1ns/1ps
module ispi_port_properties (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // Link and sideband
  input wire logic        select_n_i,
  input wire logic        miso_oe_o,
  input wire logic        instrument_irq_n_o,
  input wire logic        host_go_out_o,
  input wire logic        irq_req_i,
  // Configuration
  input wire logic        cfg_line_0_i,
  input wire logic        cfg_line_1_oe_o,
  input wire logic        cfg_line_2_o,
  input wire logic        cfg_master_reset_o,
  input wire logic        load_done_i,
  input wire logic        load_crc_err_i,
  input wire logic        post_crc_en_i,
  input wire logic        post_crc_err_i,
  // Frame stream
  input wire logic        frame_valid_o,
  input wire logic        frame_ready_i,
  input wire logic [15:0] frame_cmd_o
);
  // =============================================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_go_reset: assert property (disable iff (1'b0) srst_i |=> host_go_out_o)
    else $error("ready flag low after reset");
  chk_irq_reset: assert property (disable iff (1'b0) srst_i |=> instrument_irq_n_o)
    else $error("interrupt active after reset");
  chk_irq_follow: assert property (irq_req_i |=> !instrument_irq_n_o)
    else $error("interrupt request not shown");
  chk_miso_float: assert property (select_n_i [*5] |-> !miso_oe_o)
    else $error("master-in driven while deselected");
  chk_clear_init: assert property (cfg_master_reset_o |-> cfg_line_1_oe_o && !cfg_line_2_o)
    else $error("init not low while clearing");
  chk_prog_reset: assert property ($fell(cfg_line_0_i) |-> ##[1:6] cfg_master_reset_o)
    else $error("program request gave no master reset");
  chk_power_clear: assert property ($fell(srst_i) |-> cfg_master_reset_o)
    else $error("no clearing after power-up");
  chk_done_cause: assert property ($rose(cfg_line_2_o) |-> $past(load_done_i) || $past(load_done_i, 2))
    else $error("done without finished load");
  chk_crc_init: assert property (load_crc_err_i && !cfg_master_reset_o && !cfg_line_2_o
    |-> ##[1:3] cfg_line_1_oe_o)
    else $error("load check error not on init");
  chk_post_init: assert property (post_crc_en_i && post_crc_err_i && cfg_line_2_o
    |-> ##[1:3] cfg_line_1_oe_o)
    else $error("post-load error not on init");
  chk_frame_hold: assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_cmd_o))
    else $error("frame dropped before taken");
endmodule

bind ispi_port ispi_port_properties i_ispi_port_properties (.*);

// file: bench/ispi_host.sv
/*
  Host board serial master model: mode-0 frames, MSB first.
  Assumes the bench wires it to the port's link pins.
*/
`timescale 1ns/1ps
module ispi_host (
  // Link
  output logic       sck_o,
  output logic       mosi_o,
  output logic       select_n_o,
  input  wire logic  miso_i,
  input  wire logic  miso_oe_i,
  input  wire logic  host_go_i,
  // Captured reply
  output logic [7:0] reply_o
);
  // =============================================================
  // Idle levels, serial clock stands low outside frames
  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    select_n_o = 1'b1;
    reply_o = 8'h00;
  end
  // Frame of 16 + n bits, cut short after cut bits if nonzero
  task automatic send(input logic [15:0] cmd, input logic [31:0] dat, input int n, input int cut);
    logic [47:0] sr;
    int i;
    sr = {cmd, dat << (32 - n)};
    select_n_o = 1'b0;
    #250;
    for (i = 0; i < 16 + n; i++) begin
      if (cut != 0 && i == cut) break;
      while (i % 8 == 0 && !host_go_i) #10;
      mosi_o = sr[47 - i];
      #62.5 sck_o = 1'b1;
      if (i < 8) reply_o = {reply_o[6:0], miso_oe_i ? miso_i : ~reply_o[0]};
      #62.5 sck_o = 1'b0;
    end
    #250 select_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #250;
  endtask
endmodule

// file: bench/ispi_port_bench.sv
/*
  Self-checking bench of the serial slave port.
  Assumes the host model drives the link and the bench the rest.
*/
`timescale 1ns/1ps
module ispi_port_bench;
  logic clk_i, srst_i = 1, sys_n = 1, prog_n = 1, ld_done = 0, ld_err = 0;
  logic post_en = 0, post_err = 0, f_ready = 0, irq_req = 0;
  logic [7:0] reply = 8'ha5;
  wire sck, mosi, sel_n, miso, miso_oe, irq_n, go, init_oe, done, mrst, fv;
  wire irq_oe, go_oe, init_o, done_oe;
  wire [15:0] fcmd;
  wire [31:0] fdat;
  wire [1:0] flen;
  wire [7:0] rx;
  int err_total = 0, num_checks = 0;

  ispi_host i_ispi_host (.sck_o(sck), .mosi_o(mosi), .select_n_o(sel_n), .miso_i(miso),
    .miso_oe_i(miso_oe), .host_go_i(go), .reply_o(rx));
  ispi_port i_ispi_port (.clk_i(clk_i), .srst_i(srst_i), .sck_i(sck), .mosi_i(mosi),
    .select_n_i(sel_n), .miso_o(miso), .miso_oe_o(miso_oe), .instrument_irq_n_o(irq_n),
    .instrument_irq_n_oe_o(irq_oe), .host_go_out_o(go), .host_go_out_oe_o(go_oe), .system_reset_n_i(sys_n),
    .cfg_line_0_i(prog_n), .cfg_line_1_o(init_o), .cfg_line_1_oe_o(init_oe), .cfg_line_2_o(done),
    .cfg_line_2_oe_o(done_oe), .cfg_master_reset_o(mrst), .load_done_i(ld_done), .load_crc_err_i(ld_err),
    .post_crc_en_i(post_en), .post_crc_err_i(post_err), .frame_valid_o(fv), .frame_ready_i(f_ready),
    .frame_cmd_o(fcmd), .frame_data_o(fdat), .frame_len_o(flen), .reply_byte_i(reply),
    .irq_req_i(irq_req));

  // =============================================================
  // Shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic prog_pulse;
    @(posedge clk_i) prog_n <= 1'b0;
    cyc(6);
    prog_n <= 1'b1;
  endtask

  // =============================================================
  // Scenarios
  task automatic t_reset;
    chk("go", 1, go);
    chk("irq_n", 1, irq_n);
    chk("miso_oe", 0, miso_oe);
    chk("valid", 0, fv);
    chk("clearing", 1, mrst);
    chk("irq_oe", 1, irq_oe);
    chk("go_oe", 1, go_oe);
    chk("init_o", 0, init_o);
    chk("done_oe", 1, done_oe);
  endtask
  task automatic t_irq;
    @(posedge clk_i) irq_req <= 1'b1;
    cyc(3);
    #1 chk("irq_n", 0, irq_n);
    @(posedge clk_i) irq_req <= 1'b0;
    cyc(3);
    #1 chk("irq_n", 1, irq_n);
  endtask
  task automatic t_stream;
    int i, k, low;
    logic [31:0] e;
    logic [1:0] c;
    fork
      begin
        i_ispi_host.send(16'h8001, 32'hffff_ffff, 32, 20);
        for (int j = 0; j < 9; j++)
          i_ispi_host.send({(j == 8) ? 2'd3 : 2'(j % 3), 14'(j)}, 32'hc3a5_0f1e + j, 8 << (j % 3), 0);
      end
    join_none
    low = 0;
    for (k = 0; k < 12000 && low < 20; k++) begin
      @(posedge clk_i);
      #1 low = go ? 0 : low + 1;
    end
    chk("go full", 0, go);
    for (i = 0; i < 9; i++) begin
      for (k = 0; k < 2000 && fv !== 1'b1; k++) begin
        @(posedge clk_i);
        #1;
      end
      chk("valid", 1, fv);
      c = (i == 8) ? 2'd3 : 2'(i % 3);
      e = (32'hc3a5_0f1e + i) << (32 - (8 << (i % 3)));
      e = e >> (32 - (8 << (i % 3)));
      chk("cmd", {c, 14'(i)}, fcmd);
      chk("len", c, flen);
      chk("data", e, fdat);
      @(posedge clk_i) f_ready <= 1'b1;
      @(posedge clk_i) f_ready <= 1'b0;
      #1;
    end
    cyc(2);
    #1 chk("empty", 0, fv);
    chk("go", 1, go);
    chk("reply", reply, rx);
  endtask
  task automatic t_cfg;
    @(posedge clk_i) ld_done <= 1'b1;
    cyc(300);
    #1 chk("done", 1, done);
    @(posedge clk_i) ld_done <= 1'b0;
    ld_err <= 1'b1;
    prog_pulse();
    #1 chk("master", 1, mrst);
    chk("init", 1, init_oe);
    chk("done", 0, done);
    cyc(300);
    #1 chk("init err", 1, init_oe);
    chk("done err", 0, done);
    @(posedge clk_i) ld_err <= 1'b0;
    ld_done <= 1'b1;
    prog_pulse();
    cyc(300);
    #1 chk("init ok", 0, init_oe);
    chk("done", 1, done);
    @(posedge clk_i) post_en <= 1'b1;
    post_err <= 1'b1;
    cyc(4);
    #1 chk("init post", 1, init_oe);
    @(posedge clk_i) post_err <= 1'b0;
  endtask
  task automatic t_sysrst;
    @(posedge clk_i) sys_n <= 1'b0;
    cyc(5);
    #1 chk("master", 1, mrst);
    chk("done", 0, done);
    chk("go", 1, go);
    @(posedge clk_i) sys_n <= 1'b1;
    cyc(300);
    #1 chk("done", 1, done);
  endtask

  // =============================================================
  // Clock, sequence and watchdog
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    cyc(6);
    srst_i <= 1'b0;
    @(posedge clk_i);
    #1 t_reset();
    t_irq();
    t_stream();
    t_cfg();
    t_sysrst();
    test_done();
  end
  initial begin
    #800us;
    err_total++;
    test_done();
  end
endmodule
